//--- hw/cfpc_alu.sv
// arithmetic, flag and skip evaluation for one executed command
module cfpc_alu (
  // operation
  input wire cfpc_pkg::cfpc_op_t op,
  input wire logic [2:0] bit_sel,
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  // results
  output logic [7:0] result,
  output logic carry_out,
  output logic nibble_out,
  output logic zero_out,
  output logic skip,
  output logic write_acc,
  output logic write_result,
  output logic upd_carry,
  output logic upd_nibble,
  output logic upd_zero
);
  import cfpc_pkg::*;

  logic [8:0] sum9;
  logic [4:0] nib5;
  logic cin_used;

  always_comb begin
    cin_used = (op == OP_ADC) ? carry_in : 1'b0;
    sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin_used};
    nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin_used};
    result = 8'h00;
    carry_out = 1'b0;
    nibble_out = 1'b0;
    skip = 1'b0;
    write_acc = 1'b0;
    write_result = 1'b0;
    upd_carry = 1'b0;
    upd_nibble = 1'b0;
    upd_zero = 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        result = sum9[7:0];
        carry_out = sum9[8];
        nibble_out = nib5[4];
        write_acc = 1'b1;
        {upd_carry, upd_nibble, upd_zero} = 3'b111;
      end
      OP_SUB: begin
        result = 8'(a - b);
        carry_out = (a >= b);
        nibble_out = (a[3:0] >= b[3:0]);
        write_acc = 1'b1;
        {upd_carry, upd_nibble, upd_zero} = 3'b111;
      end
      OP_RLC: begin
        result = {a[6:0], carry_in};
        carry_out = a[7];
        write_acc = 1'b1;
        upd_carry = 1'b1;
      end
      OP_RRC: begin
        result = {carry_in, a[7:1]};
        carry_out = a[0];
        write_acc = 1'b1;
        upd_carry = 1'b1;
      end
      OP_COMPARE_SKIP: begin
        result = 8'(a - b);
        carry_out = (a >= b);
        skip = (a == b);
        {upd_carry, upd_zero} = 2'b11;
      end
      OP_INC_ACC_SKIP, OP_INC_MEM_SKIP: begin
        result = 8'(b + 8'h01);
        skip = (b == 8'hff);
        write_acc = (op == OP_INC_ACC_SKIP);
        write_result = (op == OP_INC_MEM_SKIP);
      end
      OP_DEC_ACC_SKIP, OP_DEC_MEM_SKIP: begin
        result = 8'(b - 8'h01);
        skip = (b == 8'h01);
        write_acc = (op == OP_DEC_ACC_SKIP);
        write_result = (op == OP_DEC_MEM_SKIP);
      end
      OP_BIT_CLEAR_SKIP: skip = ~b[bit_sel];
      OP_BIT_SET_SKIP: skip = b[bit_sel];
      default: result = 8'h00;
    endcase
    zero_out = (result == 8'h00);
  end

endmodule

//--- hw/cfpc_core.sv
// accumulator, status flags, instruction pointer and pointer pair with apb
// Overview of operation
// - eight-bit accumulator held in its own register, outside data memory.
// - no automatic save on entry; save and restore copy accumulator and flags.
// - status flags: cause 7:6, low-voltage 5:4, carry 2, nibble 1, zero 0.
// - cause pair: 00 watchdog, 10 low voltage, 11 reset pin, 01 reserved.
// - high low-voltage flag follows its detector only when its option is on.
// - mid low-voltage flag follows its detector only when its option is on.
// - carry set on carry, no borrow, rotated-out one, compare not negative.
// - nibble carry set on low nibble carry or no nibble borrow.
// - zero flag set when an add, subtract or compare result is zero.
// - thirteen-bit pointer, five high and eight low bits, cleared by reset.
// - each executed command other than jump, a taken skip or low-byte add or subtract advances the pointer by one.
// - jump loads the full thirteen-bit destination.
// - a true skip condition advances the pointer by two.
// - compare skips when accumulator equals operand.
// - increment skips when the operand wraps from ff to zero.
// - decrement skips when the operand goes from one to zero.
// - bit test skips when the tested bit matches the condition.
// - adding accumulator to low byte carries into the high byte.
// - subtracting from the low byte never changes the high byte.
// - writing the low byte jumps within the current high page.
// - two pointer bytes form the indirect address, upper is bank.
//
// Implementation choice: the APB slave port.
module cfpc_core (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cfpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [cfpc_pkg::DATA_W-1:0] pwdata,
  output logic [cfpc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitor and reset source
  input wire logic [1:0] reset_cause_in,
  input wire logic low_volt_high_in,
  input wire logic low_volt_mid_in,
  input wire logic low_volt_high_option,
  input wire logic low_volt_mid_option,
  // core state
  output logic [7:0] work_accumulator,
  output logic [7:0] status_flag_register,
  output logic [12:0] instruction_pointer,
  output logic [15:0] indirect_pair_access
);
  import cfpc_pkg::*;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] ptr_low;
    logic [7:0] ptr_high;
    logic [12:0] ip;
    logic [7:0] operand;
    logic [7:0] command;
    logic [12:0] target;
    logic [7:0] result;
    logic [7:0] save_acc;
    logic [7:0] save_flags;
    logic cause_pend;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cfpc_state_t;

  cfpc_state_t q;
  cfpc_state_t next_q;

  logic acc_phase;
  logic done;
  logic wr;
  logic exec;
  logic mapped;
  logic [7:0] idx;
  logic [7:0] rd_val;
  cfpc_op_t op;
  logic [7:0] alu_result;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_skip;
  logic alu_wr_acc;
  logic alu_wr_res;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic [12:0] ip_calc;
  logic ip_carry;

  assign acc_phase = psel & penable;
  assign done = acc_phase & q.pready;
  assign idx = paddr[9:2];
  assign wr = done & pwrite & mapped;
  assign exec = wr & (idx == IDX_COMMAND);
  assign op = cfpc_op_t'(pwdata[7:4]);

  // address decode and read mux
  always_comb begin
    rd_val = 8'h00;
    mapped = 1'b0;
    if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
      mapped = 1'b1;
      case (idx)
        IDX_PTR_LOW: rd_val = q.ptr_low;
        IDX_PTR_HIGH: rd_val = q.ptr_high;
        IDX_STATUS: rd_val = q.flags;
        IDX_ACC: rd_val = q.acc;
        IDX_OPERAND: rd_val = q.operand;
        IDX_COMMAND: rd_val = q.command;
        IDX_TARGET_LOW: rd_val = q.target[7:0];
        IDX_TARGET_HIGH: rd_val = {3'b000, q.target[12:8]};
        IDX_RESULT: rd_val = q.result;
        IDX_CONTROL: rd_val = 8'h00;
        IDX_IP_LOW: rd_val = q.ip[7:0];
        IDX_IP_HIGH: rd_val = {3'b000, q.ip[12:8]};
        default: mapped = 1'b0;
      endcase
    end
  end

  cfpc_alu i_cfpc_alu (
    .op(op),
    .bit_sel(pwdata[2:0]),
    .a(q.acc),
    .b(q.operand),
    .carry_in(q.flags[FLAG_C]),
    .result(alu_result),
    .carry_out(alu_c),
    .nibble_out(alu_dc),
    .zero_out(alu_z),
    .skip(alu_skip),
    .write_acc(alu_wr_acc),
    .write_result(alu_wr_res),
    .upd_carry(upd_c),
    .upd_nibble(upd_dc),
    .upd_zero(upd_z)
  );

  cfpc_ip_next i_cfpc_ip_next (
    .ip(q.ip),
    .exec(exec),
    .op(op),
    .skip(alu_skip),
    .target(q.target),
    .acc(q.acc),
    .use_carry(pwdata[0]),
    .carry_flag(q.flags[FLAG_C]),
    .low_write(wr & (idx == IDX_IP_LOW)),
    .high_write(wr & (idx == IDX_IP_HIGH)),
    .byte_data(pwdata[7:0]),
    .next_ip(ip_calc),
    .low_carry(ip_carry)
  );

  always_comb begin
    next_q = q;
    // one wait state: ready is raised in the second access cycle
    next_q.pready = acc_phase & ~q.pready;
    next_q.pslverr = acc_phase & ~q.pready & ~mapped;
    if (acc_phase & ~q.pready) begin
      next_q.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end
    next_q.ip = ip_calc;
    if (wr) begin
      case (idx)
        IDX_PTR_LOW: next_q.ptr_low = pwdata[7:0];
        IDX_PTR_HIGH: next_q.ptr_high = pwdata[7:0];
        IDX_STATUS: begin
          next_q.flags = (q.flags & ~STATUS_WMASK) |
            (pwdata[7:0] & STATUS_WMASK);
        end
        IDX_ACC: next_q.acc = pwdata[7:0];
        IDX_OPERAND: next_q.operand = pwdata[7:0];
        IDX_COMMAND: next_q.command = pwdata[7:0];
        IDX_TARGET_LOW: next_q.target[7:0] = pwdata[7:0];
        IDX_TARGET_HIGH: next_q.target[12:8] = pwdata[4:0];
        IDX_CONTROL: begin
          if (pwdata[CTRL_SAVE]) begin
            next_q.save_acc = q.acc;
            next_q.save_flags = q.flags;
          end else if (pwdata[CTRL_RESTORE]) begin
            next_q.acc = q.save_acc;
            next_q.flags = (q.flags & ~STATUS_WMASK) |
              (q.save_flags & STATUS_WMASK);
          end
        end
        default: next_q.result = q.result;
      endcase
    end
    if (exec) begin
      if (alu_wr_acc) begin
        next_q.acc = alu_result;
      end
      if (alu_wr_res) begin
        next_q.result = alu_result;
      end
      if (upd_c) begin
        next_q.flags[FLAG_C] = alu_c;
      end
      if (upd_dc) begin
        next_q.flags[FLAG_DC] = alu_dc;
      end
      if (upd_z) begin
        next_q.flags[FLAG_Z] = alu_z;
      end
    end
    // detector flags are read-only and follow the supply each cycle while their option is on, else they read zero
    next_q.flags[FLAG_LV_HIGH] = low_volt_high_option & low_volt_high_in;
    next_q.flags[FLAG_LV_MID] = low_volt_mid_option & low_volt_mid_in;
    next_q.flags[FLAG_UNUSED] = 1'b0;
    // reset source is caught in the first cycle after release
    if (q.cause_pend) begin
      next_q.flags[FLAG_CAUSE_HI:FLAG_CAUSE_LO] = reset_cause_in;
      next_q.cause_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.ip <= IP_RESET;
      q.flags <= FLAG_RESET;
      q.cause_pend <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign work_accumulator = q.acc;
  assign status_flag_register = q.flags;
  assign instruction_pointer = q.ip;
  assign indirect_pair_access = {q.ptr_high, q.ptr_low};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic plain_step;
  assign plain_step = exec && op != OP_JUMP && op != OP_ADD_PCL &&
    op != OP_SUB_PCL;

  a_ip_single_step:
  assert property (plain_step && !alu_skip |=>
    instruction_pointer == 13'($past(instruction_pointer) + 13'h0001))
  else $error("pointer did not advance by one");

  a_ip_skip_two:
  assert property (plain_step && alu_skip |=>
    instruction_pointer == 13'($past(instruction_pointer) + 13'h0002))
  else $error("skip did not advance pointer by two");

  a_jump_load:
  assert property (exec && op == OP_JUMP |=>
    instruction_pointer == $past(q.target))
  else $error("jump destination not loaded");

  a_pcl_carry_up:
  assert property (exec && op == OP_ADD_PCL && ip_carry |=>
    instruction_pointer[12:8] ==
      5'($past(instruction_pointer[12:8]) + 5'h01))
  else $error("low byte overflow did not bump high byte");

  a_pcl_no_borrow:
  assert property (exec && op == OP_SUB_PCL |=>
    $stable(instruction_pointer[12:8]))
  else $error("subtraction changed the high byte");

  a_low_write_page:
  assert property (wr && idx == IDX_IP_LOW |=>
    instruction_pointer == {$past(instruction_pointer[12:8]),
      $past(pwdata[7:0])})
  else $error("low byte write left the page");

  a_unused_bit_zero:
  assert property (status_flag_register[FLAG_UNUSED] == 1'b0)
  else $error("unused status bit set");

  a_lv_high_follow:
  assert property (rst_n |=> status_flag_register[FLAG_LV_HIGH] ==
    $past(low_volt_high_option & low_volt_high_in))
  else $error("high low-voltage flag wrong");

  a_lv_mid_follow:
  assert property (rst_n |=> status_flag_register[FLAG_LV_MID] ==
    $past(low_volt_mid_option & low_volt_mid_in))
  else $error("mid low-voltage flag wrong");

  a_cause_capture:
  assert property (q.cause_pend && rst_n |=>
    status_flag_register[FLAG_CAUSE_HI:FLAG_CAUSE_LO] ==
      $past(reset_cause_in) ##1 !q.cause_pend)
  else $error("reset cause not captured");

  a_zero_flag_set:
  assert property (exec && upd_z |=>
    status_flag_register[FLAG_Z] == ($past(alu_result) == 8'h00))
  else $error("zero flag mismatch");

  a_restore_acc:
  assert property (wr && idx == IDX_CONTROL && !pwdata[CTRL_SAVE] &&
    pwdata[CTRL_RESTORE] |=> work_accumulator == $past(q.save_acc))
  else $error("restore did not reload accumulator");

  a_add_carry:
  assert property (exec && op == OP_ADD |=>
    status_flag_register[FLAG_C] ==
      ($past({1'b0, q.acc} + {1'b0, q.operand}) > 9'h0ff))
  else $error("add carry flag wrong");

  a_sub_carry:
  assert property (exec && op == OP_SUB |=>
    status_flag_register[FLAG_C] == $past(q.acc >= q.operand))
  else $error("subtract carry flag wrong");

  a_add_nibble:
  assert property (exec && op == OP_ADD |=>
    status_flag_register[FLAG_DC] ==
      ($past({1'b0, q.acc[3:0]} + {1'b0, q.operand[3:0]}) > 5'h0f))
  else $error("add nibble carry flag wrong");

  a_compare_skip:
  assert property (exec && op == OP_COMPARE_SKIP && q.acc == q.operand |=>
    instruction_pointer == 13'($past(instruction_pointer) + 13'h0002))
  else $error("equal compare did not skip");

  a_inc_wrap_skip:
  assert property (exec && op == OP_INC_MEM_SKIP && q.operand == 8'hff |=>
    instruction_pointer == 13'($past(instruction_pointer) + 13'h0002))
  else $error("increment wrap did not skip");

  a_dec_zero_skip:
  assert property (exec && op == OP_DEC_ACC_SKIP && q.operand == 8'h01 |=>
    instruction_pointer == 13'($past(instruction_pointer) + 13'h0002) &&
    work_accumulator == 8'h00)
  else $error("decrement to zero did not skip");

  a_ptr_high_load:
  assert property (wr && idx == IDX_PTR_HIGH |=>
    indirect_pair_access[15:8] == $past(pwdata[7:0]))
  else $error("upper pointer byte not loaded");

  a_ready_pulse:
  assert property (pready |=> !pready)
  else $error("ready held longer than one cycle");

  c_skip_taken: cover property (plain_step && alu_skip);
  c_jump_done: cover property (exec && op == OP_JUMP);
  c_pcl_carry: cover property (exec && op == OP_ADD_PCL && ip_carry);
  c_bad_address: cover property (pready && pslverr);

endmodule

//--- hw/cfpc_ip_next.sv
// next value of the 13-bit instruction pointer
module cfpc_ip_next (
  // current pointer
  input wire logic [12:0] ip,
  // command
  input wire logic exec,
  input wire cfpc_pkg::cfpc_op_t op,
  input wire logic skip,
  input wire logic [12:0] target,
  input wire logic [7:0] acc,
  input wire logic use_carry,
  input wire logic carry_flag,
  // direct byte writes
  input wire logic low_write,
  input wire logic high_write,
  input wire logic [7:0] byte_data,
  // result
  output logic [12:0] next_ip,
  output logic low_carry
);
  import cfpc_pkg::*;

  logic [8:0] low_sum;

  always_comb begin
    low_sum = {1'b0, ip[7:0]} + {1'b0, acc} +
      {8'h00, use_carry & carry_flag};
    low_carry = 1'b0;
    next_ip = ip;
    if (low_write) begin
      next_ip = {ip[12:8], byte_data};
    end else if (high_write) begin
      next_ip = {byte_data[4:0], ip[7:0]};
    end else if (exec) begin
      case (op)
        OP_JUMP: next_ip = target;
        OP_ADD_PCL: begin
          low_carry = low_sum[8];
          next_ip = {5'(ip[12:8] + {4'h0, low_sum[8]}), low_sum[7:0]};
        end
        OP_SUB_PCL: next_ip = {ip[12:8], 8'(ip[7:0] - acc)};
        default: begin
          next_ip = 13'(ip + (skip ? IP_SKIP_STEP : IP_STEP));
        end
      endcase
    end
  end

endmodule

//--- hw/cfpc_pkg.sv
// shared constants and types of the core flags and instruction pointer block
package cfpc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PTR_LOW = 8'h80;
  localparam logic [7:0] IDX_PTR_HIGH = 8'h81;
  localparam logic [7:0] IDX_STATUS = 8'h86;
  localparam logic [7:0] IDX_ACC = 8'h90;
  localparam logic [7:0] IDX_OPERAND = 8'h91;
  localparam logic [7:0] IDX_COMMAND = 8'h92;
  localparam logic [7:0] IDX_TARGET_LOW = 8'h93;
  localparam logic [7:0] IDX_TARGET_HIGH = 8'h94;
  localparam logic [7:0] IDX_RESULT = 8'h95;
  localparam logic [7:0] IDX_CONTROL = 8'h96;
  localparam logic [7:0] IDX_IP_LOW = 8'hce;
  localparam logic [7:0] IDX_IP_HIGH = 8'hcf;

  // status flag field positions
  localparam int unsigned FLAG_Z = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_C = 2;
  localparam int unsigned FLAG_UNUSED = 3;
  localparam int unsigned FLAG_LV_MID = 4;
  localparam int unsigned FLAG_LV_HIGH = 5;
  localparam int unsigned FLAG_CAUSE_LO = 6;
  localparam int unsigned FLAG_CAUSE_HI = 7;
  localparam logic [7:0] STATUS_WMASK = 8'hc7;

  // control register bits
  localparam int unsigned CTRL_SAVE = 0;
  localparam int unsigned CTRL_RESTORE = 1;

  // reset values and steps
  localparam logic [12:0] IP_RESET = 13'h0000;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [12:0] IP_STEP = 13'h0001;
  localparam logic [12:0] IP_SKIP_STEP = 13'h0002;

  // reset cause codes
  localparam logic [1:0] CAUSE_WATCHDOG = 2'b00;
  localparam logic [1:0] CAUSE_RESERVED = 2'b01;
  localparam logic [1:0] CAUSE_LOW_VOLT = 2'b10;
  localparam logic [1:0] CAUSE_PIN = 2'b11;

  typedef enum logic [3:0] {
    OP_STEP = 4'b0000,
    OP_ADD = 4'b0001,
    OP_ADC = 4'b0010,
    OP_SUB = 4'b0011,
    OP_RLC = 4'b0100,
    OP_RRC = 4'b0101,
    OP_COMPARE_SKIP = 4'b0110,
    OP_INC_ACC_SKIP = 4'b0111,
    OP_INC_MEM_SKIP = 4'b1000,
    OP_DEC_ACC_SKIP = 4'b1001,
    OP_DEC_MEM_SKIP = 4'b1010,
    OP_BIT_CLEAR_SKIP = 4'b1011,
    OP_BIT_SET_SKIP = 4'b1100,
    OP_JUMP = 4'b1101,
    OP_ADD_PCL = 4'b1110,
    OP_SUB_PCL = 4'b1111
  } cfpc_op_t;

endpackage

//--- test/cfpc_core_tb.sv
// self-checking bench for the core flags and instruction pointer block
module cfpc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cfpc_pkg::*;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cause_in = 2'b11;
  logic lvh_in = 1'b0;
  logic lvm_in = 1'b0;
  logic lvh_opt = 1'b0;
  logic lvm_opt = 1'b0;
  logic [7:0] acc_o;
  logic [7:0] flags_o;
  logic [12:0] ip_o;
  logic [15:0] pair_o;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd_v;
  logic er_v;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r;
  logic [2:0] f;
  logic [2:0] s;
  logic [3:0] op;
  logic [10:0] e;
  logic [12:0] ip0;
  logic [12:0] t;
  logic sk;

  always #5 mclk = ~mclk;

  cfpc_core i_cfpc_core (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_cause_in(cause_in),
    .low_volt_high_in(lvh_in), .low_volt_mid_in(lvm_in),
    .low_volt_high_option(lvh_opt), .low_volt_mid_option(lvm_opt),
    .work_accumulator(acc_o), .status_flag_register(flags_o),
    .instruction_pointer(ip_o), .indirect_pair_access(pair_o)
  );

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, returns a settled cycle after the completing edge
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rd_v, er_v);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000, rd_v, er_v);
    check(rd_v, exp);
  endtask

  task automatic do_reset(input logic [1:0] c);
    @(posedge mclk);
    cause_in <= c;
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic jump_to(input logic [12:0] d);
    wr(IDX_TARGET_LOW, {24'h00_0000, d[7:0]});
    wr(IDX_TARGET_HIGH, {27'h000_0000, d[12:8]});
    wr(IDX_COMMAND, {24'h00_0000, OP_JUMP, 4'h0});
  endtask

  // expected {result, carry, nibble carry, zero} of ops 1 to 5
  function automatic logic [10:0] alu_exp(input logic [3:0] o,
      input logic [7:0] x, input logic [7:0] y, input logic [2:0] fl);
    logic [8:0] sm;
    logic [4:0] nb;
    logic ci;
    ci = (o == 4'h2) & fl[2];
    case (o)
      4'h1, 4'h2: begin
        sm = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        nb = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        return {sm[7:0], sm[8], nb[4], sm[7:0] == 8'h00};
      end
      4'h3: begin
        sm = {1'b0, x} - {1'b0, y};
        nb = {1'b0, x[3:0]} - {1'b0, y[3:0]};
        return {sm[7:0], ~sm[8], ~nb[4], sm[7:0] == 8'h00};
      end
      4'h4: return {x[6:0], fl[2], x[7], fl[1:0]};
      default: return {fl[2], x[7:1], x[0], fl[1:0]};
    endcase
  endfunction

  function automatic logic skip_exp(input int o, input logic [7:0] x,
      input logic [7:0] y, input logic [2:0] sel);
    case (o)
      6: return x == y;
      7, 8: return y == 8'hff;
      9, 10: return y == 8'h01;
      11: return y[sel] == 1'b0;
      default: return y[sel] == 1'b1;
    endcase
  endfunction

  initial begin
    void'($urandom(32'h941794ee));
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i));
      check(ip_o, IP_RESET);
      check(flags_o, {2'(i), 6'h00});
    end
    $display("test reset done");
    wr(IDX_STATUS, 32'h0000_00ff);
    rdchk(IDX_STATUS, 32'h0000_00c7);
    check(flags_o, 8'hc7);
    apb(1'b0, 8'ha0, 32'h0000_0000, rd_v, er_v);
    check({er_v, rd_v[7:0]}, 9'h100);
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      wr(IDX_PTR_LOW, {24'h00_0000, a});
      wr(IDX_PTR_HIGH, {24'h00_0000, b});
      check(pair_o, {b, a});
      rdchk(IDX_PTR_LOW, a);
    end
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      {lvh_opt, lvm_opt, lvh_in, lvm_in} <= 4'(i);
      repeat (3) @(posedge mclk);
      #1;
      check(flags_o[5], i[3] & i[1]);
      check(flags_o[4], i[2] & i[0]);
    end
    @(posedge mclk);
    {lvh_opt, lvm_opt, lvh_in, lvm_in} <= 4'h0;
    $display("test low voltage done");
    for (int i = 0; i < 60; i++) begin
      op = 4'($urandom_range(1, 5));
      {a, b} = (i == 0) ? 16'h5555 : (i == 1) ? 16'hff01 : 16'($urandom);
      {a, b} = (i == 2) ? 16'h0f01 : {a, b};
      f = 3'($urandom);
      wr(IDX_ACC, {24'h00_0000, a});
      wr(IDX_OPERAND, {24'h00_0000, b});
      wr(IDX_STATUS, {24'h00_0000, CAUSE_PIN, 3'b000, f});
      ip0 = ip_o;
      wr(IDX_COMMAND, {24'h00_0000, op, 4'h0});
      e = alu_exp(op, a, b, f);
      check(acc_o, e[10:3]);
      check(flags_o[2:0], e[2:0]);
      check(ip_o, 13'(ip0 + IP_STEP));
    end
    $display("test arithmetic done");
    for (int j = 6; j <= 12; j++) begin
      for (int k = 0; k < 4; k++) begin
        b = (k == 0) ? 8'hff : (k == 1) ? 8'h01 : 8'($urandom);
        b = (k == 2) ? 8'h00 : b;
        a = (k == 3) ? b : 8'($urandom);
        s = 3'($urandom);
        wr(IDX_ACC, {24'h00_0000, a});
        wr(IDX_OPERAND, {24'h00_0000, b});
        wr(IDX_STATUS, {24'h00_0000, CAUSE_PIN, 6'h00});
        ip0 = ip_o;
        wr(IDX_COMMAND, {24'h00_0000, 4'(j), 1'b0, s});
        sk = skip_exp(j, a, b, s);
        r = (j == 7 || j == 8) ? b + 8'h01 : b - 8'h01;
        check(ip_o, 13'(ip0 + (sk ? IP_SKIP_STEP : IP_STEP)));
        if (j == 6) check(flags_o[2:0], {a >= b, 1'b0, a == b});
        if (j == 7 || j == 9) check(acc_o, r);
        if (j == 8 || j == 10) rdchk(IDX_RESULT, r);
        if (j > 10) check(acc_o, a);
      end
    end
    $display("test skips done");
    for (int i = 0; i < 8; i++) begin
      t = (i == 0) ? 13'h0aff : 13'($urandom);
      jump_to(t);
      check(ip_o, t);
      wr(IDX_COMMAND, {24'h00_0000, OP_STEP, 4'h0});
      check(ip_o, 13'(t + IP_STEP));
    end
    for (int i = 0; i < 3; i++) begin
      t = (i == 0) ? 13'h0310 : 13'h03f0;
      a = (i == 1) ? 8'h0f : 8'h20;
      r = (i == 0) ? 8'hf0 : (i == 1) ? 8'he1 : 8'he0;
      jump_to(t);
      wr(IDX_ACC, {24'h00_0000, a});
      wr(IDX_STATUS, {24'h00_0000, CAUSE_PIN, 6'h04});
      wr(IDX_COMMAND, {24'h00_0000, r});
      t = (i == 0) ? 13'h03f0 : (i == 1) ? 13'h0400 : 13'h0410;
      check(ip_o, t);
      check(flags_o[2:0], 3'b100);
    end
    jump_to(13'h0323);
    wr(IDX_IP_LOW, 32'h0000_0028);
    check(ip_o, 13'h0328);
    wr(IDX_IP_LOW, 32'h0000_0000);
    check(ip_o, 13'h0300);
    wr(IDX_IP_HIGH, 32'h0000_00f5);
    check(ip_o, 13'h1500);
    rdchk(IDX_IP_HIGH, 32'h0000_0015);
    $display("test instruction pointer done");
    a = 8'($urandom);
    f = 3'($urandom);
    wr(IDX_ACC, {24'h00_0000, a});
    rdchk(IDX_ACC, a);
    wr(IDX_STATUS, {24'h00_0000, CAUSE_PIN, 3'b000, f});
    wr(IDX_CONTROL, 32'h0000_0001);
    wr(IDX_ACC, {24'h00_0000, ~a});
    wr(IDX_STATUS, {24'h00_0000, CAUSE_WATCHDOG, 3'b000, ~f});
    wr(IDX_CONTROL, 32'h0000_0002);
    check(acc_o, a);
    check(flags_o, {CAUSE_PIN, 3'b000, f});
    $display("test save and restore done");
    print_verdict();
  end
endmodule
